/* rtl/sec_supervisor_pkg.sv */
`default_nettype none
package sec_supervisor_pkg;

  // ******************************************************************
  // Sizes and reset values
  // ******************************************************************
  localparam int unsigned NUM_DET       = 8;
  localparam int unsigned NUM_PART      = 4;
  localparam int unsigned ADDR_W        = 32;
  localparam int unsigned ID_W          = 32;
  localparam logic [NUM_DET-1:0] DET_RST_SEL_DEF = 8'hFF;
  localparam logic [ADDR_W-1:0]  BASE_DEF = 32'h0000_0000;
  localparam logic [ADDR_W-1:0]  LIMIT_DEF = 32'h0000_0000;

  // ******************************************************************
  // Address map of the valid memory space
  // ******************************************************************
  localparam logic [ADDR_W-1:0] ROM_LO   = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] ROM_HI   = 32'h0000_FFFF;
  localparam logic [ADDR_W-1:0] FLASH_LO = 32'h0010_0000;
  localparam logic [ADDR_W-1:0] FLASH_HI = 32'h001F_FFFF;
  localparam logic [ADDR_W-1:0] RAM_LO   = 32'h2000_0000;
  localparam logic [ADDR_W-1:0] RAM_HI   = 32'h2000_FFFF;
  localparam logic [ADDR_W-1:0] SFR_LO   = 32'h4000_0000;
  localparam logic [ADDR_W-1:0] SFR_HI   = 32'h4000_FFFF;

  // ******************************************************************
  // Protection attribute field positions
  // ******************************************************************
  localparam int unsigned ATTR_PRIV_RD = 0;
  localparam int unsigned ATTR_PRIV_WR = 1;
  localparam int unsigned ATTR_USER_RD = 2;
  localparam int unsigned ATTR_USER_WR = 3;
  localparam int unsigned ATTR_EN      = 4;
  localparam logic [4:0]  ATTR_DEF     = 5'h03;

  typedef logic [4:0] attr_t;

  // Access kinds on the memory port.
  typedef enum logic [1:0] {
    ACC_READ  = 2'h0,
    ACC_WRITE = 2'h1,
    ACC_ERASE = 2'h3
  } acc_kind_e;

  // Mode of the test/normal lifecycle, Gray coded along its path.
  typedef enum logic [1:0] {
    LC_LOCKED = 2'h0,
    LC_TEST   = 2'h1,
    LC_NORMAL = 2'h3
  } lc_state_e;

  // One memory access request.
  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
    acc_kind_e         kind;
    logic              priv;
  } mem_req_s;

  // One protection partition.
  typedef struct packed {
    logic [ADDR_W-1:0] base;
    logic [ADDR_W-1:0] limit;
    attr_t             attr;
  } part_s;

  // Nonvolatile state carried in and out.
  typedef struct packed {
    logic normal;
    logic boot_flash_lock;
    logic rom_hidden;
    logic id_written;
  } nv_s;

endpackage
`default_nettype wire

/* rtl/sec_supervisor.sv */
`default_nettype none

module sec_supervisor
  import sec_supervisor_pkg::*;
#(
  parameter int unsigned N_DET  = NUM_DET,
  parameter int unsigned N_PART = NUM_PART
) (
  // Clock and reset.
  input  wire logic              i_sys_clk,
  input  wire logic              i_reset_n,
  // Detectors and their lifecycle monitor.
  input  wire logic [N_DET-1:0]  i_det_event,
  input  wire logic [N_DET-1:0]  i_det_alive,
  input  wire logic [N_DET-1:0]  i_det_rst_sel,
  input  wire logic [N_DET-1:0]  i_det_clear,
  output logic [N_DET-1:0]       o_det_status,
  output logic                   o_det_irq,
  output logic                   o_chip_reset,
  // Protection configuration.
  input  wire logic              i_cfg_we,
  input  wire logic              i_cfg_ram,
  input  wire logic [1:0]        i_cfg_idx,
  input  wire part_s             i_cfg_part,
  input  wire logic              i_flash_ro,
  // Memory access check.
  input  wire mem_req_s          i_req,
  output logic                   o_grant,
  output logic                   o_trap,
  output logic                   o_invalid_addr,
  // Lifecycle, identification and boot control.
  input  wire nv_s               i_nv,
  input  wire logic              i_pwd_ok,
  input  wire logic              i_go_normal,
  input  wire logic              i_id_we,
  input  wire logic [ID_W-1:0]   i_id_data,
  input  wire logic              i_boot_to_flash,
  input  wire logic              i_rom_hide,
  output logic [ID_W-1:0]        o_id_data,
  output nv_s                    o_nv,
  output logic                   o_nv_we,
  output logic                   o_test_mode,
  output logic                   o_boot_flash,
  // Loader command gate.
  input  wire logic              i_ldr_cmd,
  input  wire logic              i_ldr_restricted,
  input  wire logic              i_auth_ok,
  input  wire logic              i_auth_drop,
  output logic                   o_ldr_accept,
  output logic                   o_ldr_reject
);

  // ******************************************************************
  // State record
  // ******************************************************************
  // Fields: detector status and reset request, both partition tables,
  // lifecycle and stored flags, identity, loader state and the answers.
  typedef struct packed {
    logic [N_DET-1:0]  status;
    logic              rst;
    part_s [N_PART-1:0] flash_p;
    part_s [N_PART-1:0] ram_p;
    lc_state_e         lc;
    nv_s               nv;
    logic              nv_we;
    logic              nv_loaded;
    logic [ID_W-1:0]   id;
    logic              authed;
    logic              grant;
    logic              trap;
    logic              inval;
    logic              ldr_acc;
    logic              ldr_rej;
  } st_s;

  // The whole state is one record: next_st is its next value and st
  // the registered copy. Answers are fields of the record, so every
  // data output but o_det_irq and o_test_mode comes straight from a flip-flop.
  st_s st;
  st_s next_st;

  // Combinational interrupt level, the only output not taken from st.
  logic o_det_irq_c;

  // Returns true when the address falls inside an inclusive range.
  // A limit equal to the base still covers one address, and a limit
  // below the base covers nothing.
  function automatic logic in_rng(input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] lo,
                                  input logic [ADDR_W-1:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  // Checks one partition's attribute against the request.
  // Write and erase both count as writes; there is no separate erase
  // right, so erase is governed by the write bit.
  function automatic logic part_ok(input part_s p, input mem_req_s r);
    logic wr;
    wr = (r.kind != ACC_READ);
    if (r.priv) begin
      part_ok = wr ? p.attr[ATTR_PRIV_WR] : p.attr[ATTR_PRIV_RD];
    end else begin
      part_ok = wr ? p.attr[ATTR_USER_WR] : p.attr[ATTR_USER_RD];
    end
  endfunction

  // ******************************************************************
  // Next-state logic
  // ******************************************************************
  // Window decode of the memory map and partition matches.
  logic                in_rom;
  logic                in_flash;
  logic                in_ram;
  logic                in_sfr;
  logic [N_PART-1:0]   f_hit;
  logic [N_PART-1:0]   f_ok;
  logic [N_PART-1:0]   r_hit;
  logic [N_PART-1:0]   r_ok;

  // Partition matches, one per partition for each space.
  // A partition with its enable bit low never matches. After reset all
  // are disabled, so flash and RAM fall back to privileged-only rights
  // until software opens a partition.
  for (genvar g = 0; g < N_PART; g++) begin : g_part
    assign f_hit[g] = st.flash_p[g].attr[ATTR_EN] &&
                      in_rng(i_req.addr, st.flash_p[g].base,
                             st.flash_p[g].limit);
    assign f_ok[g]  = part_ok(st.flash_p[g], i_req);
    assign r_hit[g] = st.ram_p[g].attr[ATTR_EN] &&
                      in_rng(i_req.addr, st.ram_p[g].base,
                             st.ram_p[g].limit);
    assign r_ok[g]  = part_ok(st.ram_p[g], i_req);
  end

  // The windows do not overlap, so at most one of these is high.
  assign in_rom   = in_rng(i_req.addr, ROM_LO, ROM_HI);
  assign in_flash = in_rng(i_req.addr, FLASH_LO, FLASH_HI);
  assign in_ram   = in_rng(i_req.addr, RAM_LO, RAM_HI);
  assign in_sfr   = in_rng(i_req.addr, SFR_LO, SFR_HI);

  always_comb begin
    logic [N_DET-1:0] irq_ev;
    logic             ok;
    logic             bad;
    irq_ev  = '0;
    ok      = 1'b0;
    bad     = 1'b0;
    next_st = st;

    // Detectors: detection always runs, only the reaction is chosen.
    // No input masks an event: its status bit is set whatever the
    // reaction. Set wins over clear, so an event in the cycle of its
    // own clear is kept. The reset request is formed anew each cycle
    // and stands while its cause stands; a clear does not remove it.
    irq_ev = i_det_event & ~i_det_rst_sel;
    next_st.status = (st.status & ~i_det_clear) | i_det_event;
    next_st.rst = (|(i_det_event & i_det_rst_sel)) |
                  (|(~i_det_alive));

    // Protection table writes, flash or RAM bank.
    // A new entry applies from the next cycle; a request in the cycle
    // of the write is still checked against the old entry.
    if (i_cfg_we) begin
      if (i_cfg_ram) begin
        next_st.ram_p[i_cfg_idx] = i_cfg_part;
      end else begin
        next_st.flash_p[i_cfg_idx] = i_cfg_part;
      end
    end

    // Access check: map, hiding, read-only flash, partition rights.
    // An address outside every window is trapped as well as flagged,
    // so it never completes. Where partitions overlap, one hit that
    // allows the access is enough. ROM is read only and SFR space is
    // for privileged code only.
    next_st.grant = 1'b0;
    next_st.trap  = 1'b0;
    next_st.inval = 1'b0;
    if (i_req.valid) begin
      if (!(in_rom || in_flash || in_ram || in_sfr)) begin
        bad = 1'b1;
        next_st.inval = 1'b1;
      end else if (in_rom) begin
        ok = (i_req.kind == ACC_READ) && !st.nv.rom_hidden;
      end else if (in_flash) begin
        ok = (i_req.kind == ACC_READ) || !i_flash_ro;
        if (|f_hit) begin
          ok = ok && (|(f_hit & f_ok));
        end else begin
          ok = ok && i_req.priv;
        end
      end else if (in_ram) begin
        ok = (i_req.kind != ACC_ERASE);
        if (|r_hit) begin
          ok = ok && (|(r_hit & r_ok));
        end else begin
          ok = ok && i_req.priv;
        end
      end else begin
        ok = i_req.priv;
      end
      next_st.grant = ok && !bad;
      next_st.trap  = !ok;
    end

    // Lifecycle: capture stored state once after reset, then move one way.
    // Until the stored flags are loaded no flag may change, so a strobe
    // in the first cycle after reset is ignored.
    // No arc leaves normal mode, and an illegal code is sent there too,
    // so a fault can only take test rights away.
    // Each change of a stored flag pulses o_nv_we for one cycle so the
    // store takes the new o_nv.
    next_st.nv_we = 1'b0;
    if (!st.nv_loaded) begin
      next_st.nv_loaded = 1'b1;
      next_st.nv = i_nv;
      next_st.lc = i_nv.normal ? LC_NORMAL : LC_LOCKED;
    end else begin
      unique case (st.lc)
        LC_LOCKED: begin
          if (i_pwd_ok) begin
            next_st.lc = LC_TEST;
          end
        end
        LC_TEST: begin
          if (i_id_we && !st.nv.id_written) begin
            next_st.id = i_id_data;
            next_st.nv.id_written = 1'b1;
            next_st.nv_we = 1'b1;
          end
          if (i_go_normal) begin
            next_st.lc = LC_NORMAL;
            next_st.nv.normal = 1'b1;
            next_st.nv_we = 1'b1;
          end
        end
        LC_NORMAL: begin
          next_st.lc = LC_NORMAL;
        end
        default: begin
          next_st.lc = LC_NORMAL;
        end
      endcase
      // Boot mode and ROM hiding are sticky once set.
      // No input clears either flag; only the store's copy brings them
      // back after a reset.
      if (i_boot_to_flash && !st.nv.boot_flash_lock) begin
        next_st.nv.boot_flash_lock = 1'b1;
        next_st.nv_we = 1'b1;
      end
      if (i_rom_hide && !st.nv.rom_hidden) begin
        next_st.nv.rom_hidden = 1'b1;
        next_st.nv_we = 1'b1;
      end
    end

    // Loader gate: authentication state and command acceptance.
    // A drop wins over a success in the same cycle, and the boot lock
    // drops authentication for good. The answer uses the state held
    // before this cycle's success.
    if (i_auth_drop || st.nv.boot_flash_lock) begin
      next_st.authed = 1'b0;
    end else if (i_auth_ok) begin
      next_st.authed = 1'b1;
    end
    next_st.ldr_acc = i_ldr_cmd && !st.nv.boot_flash_lock &&
                      (!i_ldr_restricted || st.authed);
    next_st.ldr_rej = i_ldr_cmd && !next_st.ldr_acc;

    // The interrupt follows stored bits and this cycle's events, so
    // software sees a request without delay. Moving a detector to the
    // reset reaction masks its stored bit at once.
    o_det_irq_c = |(st.status & ~i_det_rst_sel) | (|irq_ev);
  end

  // ******************************************************************
  // State register with defined defaults after reset
  // ******************************************************************
  // Reset loads only constants. The stored flags come back in the
  // first cycle after reset, never through the reset branch, so the
  // reset path depends on no input.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st <= '0;
      for (int i = 0; i < N_PART; i++) begin
        st.flash_p[i] <= '{base: BASE_DEF, limit: LIMIT_DEF,
                           attr: ATTR_DEF};
        st.ram_p[i]   <= '{base: BASE_DEF, limit: LIMIT_DEF,
                           attr: ATTR_DEF};
      end
      st.lc <= LC_LOCKED;
    end else begin
      st <= next_st;
    end
  end

  // ******************************************************************
  // Outputs
  // ******************************************************************
  // Every output but the interrupt and o_test_mode, a decode of st.lc, is a field of the state record.
  // Answers stand one cycle; status and stored flags until changed.
  assign o_det_status   = st.status;
  assign o_det_irq      = o_det_irq_c;
  assign o_chip_reset   = st.rst;
  assign o_grant        = st.grant;
  assign o_trap         = st.trap;
  assign o_invalid_addr = st.inval;
  assign o_id_data      = st.id;
  assign o_nv           = st.nv;
  assign o_nv_we        = st.nv_we;
  assign o_test_mode    = (st.lc == LC_TEST);
  assign o_boot_flash   = st.nv.boot_flash_lock;
  assign o_ldr_accept   = st.ldr_acc;
  assign o_ldr_reject   = st.ldr_rej;

endmodule

`default_nettype wire

/* dv/sec_supervisor_monitor.sv */
`default_nettype none
// ******************************************************************
// Port checks for the security supervisor
// ******************************************************************
module sec_supervisor_monitor
  import sec_supervisor_pkg::*;
#(
  parameter int unsigned N_DET = NUM_DET
) (
  input wire logic             i_sys_clk,
  input wire logic             i_reset_n,
  input wire logic [N_DET-1:0] i_det_event,
  input wire logic [N_DET-1:0] i_det_alive,
  input wire logic [N_DET-1:0] i_det_rst_sel,
  input wire logic [N_DET-1:0] i_det_clear,
  input wire logic [N_DET-1:0] o_det_status,
  input wire logic             o_det_irq,
  input wire logic             o_chip_reset,
  input wire logic             i_flash_ro,
  input wire mem_req_s         i_req,
  input wire logic             o_grant,
  input wire logic             o_trap,
  input wire logic             o_invalid_addr,
  input wire nv_s              o_nv,
  input wire logic             o_test_mode,
  input wire logic             o_boot_flash,
  input wire logic             i_ldr_cmd,
  input wire logic             o_ldr_accept,
  input wire logic             o_ldr_reject
);
  timeunit 1ns;
  timeprecision 1ps;
  logic             to_rom;
  logic             to_flash;
  logic             in_map;
  logic [N_DET-1:0] ev_q;
  logic [N_DET-1:0] keep_q;

  // Decode the request address against the valid memory map.
  assign to_rom   = i_req.addr <= ROM_HI;
  assign to_flash = i_req.addr >= FLASH_LO && i_req.addr <= FLASH_HI;
  assign in_map   = to_rom || to_flash ||
                    (i_req.addr >= RAM_LO && i_req.addr <= RAM_HI) ||
                    (i_req.addr >= SFR_LO && i_req.addr <= SFR_HI);

  // Remember last events and the status bits that were not cleared.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ev_q   <= '0;
      keep_q <= '0;
    end else begin
      ev_q   <= i_det_event;
      keep_q <= o_det_status & ~i_det_clear;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  rst_react_a: assert property (
    (i_det_event & i_det_rst_sel) != '0 |=> o_chip_reset)
    else $error("reset reaction missing");
  dead_det_a: assert property (
    i_det_alive != '1 |=> o_chip_reset) else $error("dead detector ignored");
  status_set_a: assert property (
    i_det_event != '0 |=> (o_det_status & ev_q) == ev_q)
    else $error("event not recorded");
  status_hold_a: assert property (
    (o_det_status & ~i_det_clear) != '0 |=> (o_det_status & keep_q) == keep_q)
    else $error("status lost without clear");
  irq_level_a: assert property (
    (o_det_status & ~i_det_rst_sel) != '0 |-> o_det_irq)
    else $error("interrupt missing");
  bad_addr_a: assert property (
    i_req.valid && !in_map |=> o_trap && o_invalid_addr)
    else $error("invalid address not trapped");
  trap_excl_a: assert property (
    o_trap |-> !o_grant) else $error("trapped access granted");
  flash_ro_a: assert property (
    i_req.valid && i_flash_ro && to_flash && i_req.kind != ACC_READ |=> o_trap)
    else $error("read-only flash modified");
  rom_hide_a: assert property (
    i_req.valid && o_nv.rom_hidden && to_rom && i_req.kind == ACC_READ
    |=> o_trap) else $error("hidden rom read");
  one_way_a: assert property (
    o_nv.normal |-> !o_test_mode ##1 o_nv.normal)
    else $error("normal mode left");
  ldr_lock_a: assert property (
    i_ldr_cmd && o_boot_flash |=> o_ldr_reject && !o_ldr_accept)
    else $error("loader command in flash boot");

  // Main scenarios seen at least once.
  cover property (o_chip_reset);
  cover property (o_det_irq);
  cover property (o_invalid_addr);
  cover property (o_ldr_accept);
endmodule

bind sec_supervisor sec_supervisor_monitor #(.N_DET(N_DET))
  sec_supervisor_monitor_inst (.i_sys_clk, .i_reset_n, .i_det_event,
  .i_det_alive, .i_det_rst_sel, .i_det_clear, .o_det_status, .o_det_irq,
  .o_chip_reset, .i_flash_ro, .i_req, .o_grant, .o_trap, .o_invalid_addr,
  .o_nv, .o_test_mode, .o_boot_flash, .i_ldr_cmd, .o_ldr_accept,
  .o_ldr_reject);
`default_nettype wire

/* dv/sec_host_model.sv */
`default_nettype none
// ******************************************************************
// Outside party: test password and loader authentication
// ******************************************************************
module sec_host_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_go,
  input  wire logic       i_kind,
  input  wire logic [3:0] i_dly,
  output logic            o_busy,
  output logic            o_pwd_ok,
  output logic            o_auth_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;

  // Each exchange takes the chosen delay, then ends in one success pulse.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_busy    <= 1'b0;
      cnt       <= 4'h0;
      o_pwd_ok  <= 1'b0;
      o_auth_ok <= 1'b0;
    end else begin
      o_pwd_ok  <= 1'b0;
      o_auth_ok <= 1'b0;
      if (i_go && !o_busy) begin
        o_busy <= 1'b1;
        cnt    <= i_dly;
      end else if (o_busy && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (o_busy) begin
        o_busy    <= 1'b0;
        o_pwd_ok  <= !i_kind;
        o_auth_ok <= i_kind;
      end
    end
  end
endmodule
`default_nettype wire

/* dv/sec_supervisor_tb_top.sv */
`default_nettype none
// ******************************************************************
// Self-checking bench for the security supervisor
// ******************************************************************
module sec_supervisor_tb_top;
  import sec_supervisor_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk, i_reset_n, i_flash_ro, i_cfg_we, i_cfg_ram, i_go_normal;
  logic i_id_we, i_boot_to_flash, i_rom_hide, i_ldr_cmd, i_ldr_restricted;
  logic i_auth_drop, i_pwd_ok, i_auth_ok, o_det_irq, o_chip_reset, o_grant;
  logic o_trap, o_invalid_addr, o_nv_we, o_test_mode, o_boot_flash;
  logic o_ldr_accept, o_ldr_reject, host_go, host_kind, host_busy;
  logic [NUM_DET-1:0] i_det_event, i_det_alive, i_det_rst_sel, i_det_clear;
  logic [NUM_DET-1:0] o_det_status;
  logic [ID_W-1:0]    i_id_data, o_id_data;
  logic [1:0]         i_cfg_idx;
  logic [3:0]         host_dly;
  part_s              i_cfg_part;
  mem_req_s           i_req;
  nv_s                i_nv, o_nv;
  int                 failures, cmp_count;

  sec_supervisor sec_supervisor_inst (.i_sys_clk, .i_reset_n, .i_det_event,
    .i_det_alive, .i_det_rst_sel, .i_det_clear, .o_det_status, .o_det_irq,
    .o_chip_reset, .i_cfg_we, .i_cfg_ram, .i_cfg_idx, .i_cfg_part,
    .i_flash_ro, .i_req, .o_grant, .o_trap, .o_invalid_addr, .i_nv,
    .i_pwd_ok, .i_go_normal, .i_id_we, .i_id_data, .i_boot_to_flash,
    .i_rom_hide, .o_id_data, .o_nv, .o_nv_we, .o_test_mode, .o_boot_flash,
    .i_ldr_cmd, .i_ldr_restricted, .i_auth_ok, .i_auth_drop, .o_ldr_accept,
    .o_ldr_reject);
  sec_host_model sec_host_model_inst (.i_sys_clk, .i_reset_n, .i_go(host_go),
    .i_kind(host_kind), .i_dly(host_dly), .o_busy(host_busy),
    .o_pwd_ok(i_pwd_ok), .o_auth_ok(i_auth_ok));

  // Free-running 250 MHz clock.
  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (!ok) begin
      failures++;
      $display("ERROR at %0t: %s", $time, m);
    end
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test();
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Resets the block with a given stored state, restoring the detector reaction select.
  task automatic rst(input nv_s nv);
    @(posedge i_sys_clk);
    i_reset_n     <= 1'b0;
    i_nv          <= nv;
    i_det_rst_sel <= '1;
    repeat (4) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
  endtask

  // One memory access; expects {grant, trap, invalid} one cycle later.
  task automatic acc(input logic [31:0] a, input acc_kind_e k,
                     input logic p, input logic [2:0] e);
    @(posedge i_sys_clk);
    i_req <= '{1'b1, a, k, p};
    @(posedge i_sys_clk);
    i_req.valid <= 1'b0;
    #1 chk({o_grant, o_trap, o_invalid_addr} === e, "access result");
  endtask

  // Writes one partition of the RAM or flash bank.
  task automatic cfg(input logic ram, input logic [1:0] idx, input part_s p);
    @(posedge i_sys_clk);
    {i_cfg_we, i_cfg_ram, i_cfg_idx, i_cfg_part} <= {1'b1, ram, idx, p};
    @(posedge i_sys_clk);
    i_cfg_we <= 1'b0;
  endtask

  // One loader command; expects accept or reject.
  task automatic ldr(input logic r, input logic a);
    @(posedge i_sys_clk);
    {i_ldr_cmd, i_ldr_restricted} <= {1'b1, r};
    @(posedge i_sys_clk);
    i_ldr_cmd <= 1'b0;
    #1 chk(o_ldr_accept === a && o_ldr_reject === !a, "loader answer");
  endtask

  // Runs one host exchange and waits, bounded, for its end.
  task automatic host(input logic kind, input logic [3:0] dly);
    int n;
    @(posedge i_sys_clk);
    {host_go, host_kind, host_dly} <= {1'b1, kind, dly};
    @(posedge i_sys_clk);
    host_go <= 1'b0;
    for (n = 0; n < 40; n++) begin
      @(posedge i_sys_clk);
      #1 if (host_busy === 1'b0) break;
    end
    if (n == 40) begin
      failures++;
      $display("ERROR at %0t: host exchange hung", $time);
      end_of_test();
    end
    @(posedge i_sys_clk);
    #1;
  endtask

  // Pulses one of the single-bit controls for a cycle.
  task automatic pulse(input int which);
    @(posedge i_sys_clk);
    {i_go_normal, i_boot_to_flash, i_rom_hide} <= 3'b100 >> which;
    @(posedge i_sys_clk);
    {i_go_normal, i_boot_to_flash, i_rom_hide} <= 3'b000;
    #1 chk(o_nv_we === 1'b1, "store write");
    repeat (2) @(posedge i_sys_clk);
    #1;
  endtask

  // Interrupt reaction: sticky status and interrupt until cleared.
  task automatic det_irq();
    @(posedge i_sys_clk);
    {i_det_rst_sel, i_det_event} <= {8'hFB, 8'h04};
    @(posedge i_sys_clk);
    i_det_event <= 8'h00;
    repeat (3) @(posedge i_sys_clk);
    #1 chk(o_det_status === 8'h04 && o_det_irq === 1'b1, "irq");
    chk(o_chip_reset === 1'b0, "reset on irq reaction");
    @(posedge i_sys_clk);
    i_det_clear <= 8'h04;
    @(posedge i_sys_clk);
    i_det_clear <= 8'h00;
    #1 chk(o_det_status === 8'h00 && o_det_irq === 1'b0, "clear");
  endtask

  // Reset reaction from an event or from a dead detector.
  task automatic det_rst(input logic [7:0] ev, input logic [7:0] al);
    @(posedge i_sys_clk);
    {i_det_event, i_det_alive} <= {ev, al};
    @(posedge i_sys_clk);
    {i_det_event, i_det_alive} <= {8'h00, 8'hFF};
    #1 chk(o_chip_reset === 1'b1, "chip reset");
    rst('0);
  endtask

  // Partitions, privilege, invalid map and read-only flash.
  task automatic mem();
    acc(FLASH_LO, ACC_READ, 1'b1, 3'b100);
    acc(FLASH_LO, ACC_READ, 1'b0, 3'b010);
    acc(32'h3000_0000, ACC_READ, 1'b1, 3'b011);
    cfg(1'b1, 2'h0, '{RAM_LO, RAM_LO + 32'hFF, 5'h17});
    acc(RAM_LO + 32'h10, ACC_READ, 1'b0, 3'b100);
    acc(RAM_LO + 32'h10, ACC_WRITE, 1'b0, 3'b010);
    acc(RAM_LO + 32'h100, ACC_READ, 1'b0, 3'b010);
    cfg(1'b0, 2'h3, '{FLASH_LO, FLASH_LO + 32'hFFF, 5'h1F});
    acc(FLASH_LO + 32'h20, ACC_WRITE, 1'b0, 3'b100);
    @(posedge i_sys_clk);
    i_flash_ro <= 1'b1;
    acc(FLASH_LO + 32'h20, ACC_WRITE, 1'b1, 3'b010);
    acc(FLASH_LO + 32'h20, ACC_ERASE, 1'b1, 3'b010);
    acc(FLASH_LO + 32'h20, ACC_READ, 1'b1, 3'b100);
    @(posedge i_sys_clk);
    i_flash_ro <= 1'b0;
  endtask

  // Password entry, one-time identity, one-way switch to normal.
  task automatic life();
    #1 chk(o_test_mode === 1'b0, "test mode without password");
    host(1'b0, 4'h5);
    chk(o_test_mode === 1'b1, "test mode entry");
    for (int i = 0; i < 2; i++) begin
      @(posedge i_sys_clk);
      {i_id_we, i_id_data} <= {1'b1, 32'hA5A5_0001 + i};
      @(posedge i_sys_clk);
      i_id_we <= 1'b0;
      #1 chk(o_id_data === 32'hA5A5_0001, "identity data");
    end
    pulse(0);
    chk(o_test_mode === 1'b0 && o_nv.normal === 1'b1, "normal");
    host(1'b0, 4'h0);
    chk(o_test_mode === 1'b0, "back to test mode");
    rst(o_nv);
    #1 chk(o_nv.normal === 1'b1 && o_test_mode === 1'b0, "kept");
    rst('0);
  endtask

  // Loader gating, authentication, rom hiding and boot lock.
  task automatic boot();
    acc(ROM_LO, ACC_READ, 1'b1, 3'b100);
    ldr(1'b0, 1'b1);
    ldr(1'b1, 1'b0);
    host(1'b1, 4'h3);
    ldr(1'b1, 1'b1);
    @(posedge i_sys_clk);
    i_auth_drop <= 1'b1;
    @(posedge i_sys_clk);
    i_auth_drop <= 1'b0;
    ldr(1'b1, 1'b0);
    pulse(2);
    acc(ROM_LO + 32'h40, ACC_READ, 1'b1, 3'b010);
    pulse(1);
    chk(o_boot_flash === 1'b1, "flash boot");
    ldr(1'b0, 1'b0);
    rst(o_nv);
    #1 chk(o_boot_flash === 1'b1 && o_nv.rom_hidden === 1'b1, "lock");
    ldr(1'b0, 1'b0);
    acc(ROM_LO, ACC_READ, 1'b1, 3'b010);
  endtask

  // Main sequence.
  initial begin
    {i_reset_n, i_det_event, i_det_clear, i_cfg_we, i_cfg_ram} = '0;
    {i_cfg_idx, i_cfg_part, i_flash_ro, i_req, i_nv, i_go_normal} = '0;
    {i_id_we, i_id_data, i_boot_to_flash, i_rom_hide, i_ldr_cmd} = '0;
    {i_ldr_restricted, i_auth_drop, host_go, host_kind, host_dly} = '0;
    {i_det_alive, i_det_rst_sel} = '1;
    failures = 0;
    cmp_count = 0;
    rst('0);
    det_irq();
    det_rst(8'h20, 8'hFF);
    det_rst(8'h80, 8'hFF);
    det_rst(8'h00, 8'hFE);
    mem();
    life();
    boot();
    end_of_test();
  end
endmodule
`default_nettype wire
